//--- cap_params.sv
// read-only capability and structural parameters of the enhanced host controller
`timescale 1ns/100ps
// Overview of operation
// R01 - flag 0: consecutive port groups per companion
// R02 - flag 1: route from leading array elements
// R03 - power switch bit governs port power
// R04 - port count reads 1h to Fh
// R05 - decoded port registers equal port count
// R06 - threshold top 0: low bits micro frames
// R07 - threshold top 1: software assumes whole frame
// R08 - fixed list: 1024 entries, size bits zero
// R09 - programmable list: software picks smaller size
// R10 - software aligns frame list to 4 kB
// R11 - address bit 0 for 32, 1 for 64
// R12 - route array: fifteen 4-bit port elements
// R13 - ports per companion consistent with counts
// R14 - fields read-only, reserved bits zero
module cap_params #(
  parameter logic [3:0] N_PORTS = cap_params_pkg::NPORTS_RST,
  parameter logic [3:0] PORTS_PER_COMPANION = cap_params_pkg::NPCC_RST,
  parameter logic [3:0] N_CC = cap_params_pkg::NCC_RST,
  parameter logic ROUTING_RULE_FLAG = cap_params_pkg::PRR_RST,
  parameter logic [3:0] ISO_SCHEDULE_THRESHOLD = cap_params_pkg::IST_RST,
  parameter logic FRAME_LIST_PROGRAMMABLE = cap_params_pkg::FRAME_LIST_PROGRAMMABLE_RST,
  parameter logic WIDE = cap_params_pkg::WIDE_RST,
  parameter logic [59:0] ROUTE = cap_params_pkg::ROUTE_RST
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic rd_en_i,
  input wire logic wr_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wr_data_i,
  output logic [31:0] rd_data_o,
  output logic rd_valid_o,
  input wire logic power_strap_i,
  input wire logic [14:0] port_power_req_i,
  output logic [14:0] port_power_o,
  input wire logic [3:0] port_reg_idx_i,
  output logic port_reg_hit_o,
  input wire logic cmd_wr_i,
  input wire logic [31:0] cmd_wr_data_i,
  output logic [1:0] frame_list_size_select_o,
  output logic [10:0] frame_list_len_o,
  input wire logic [31:0] frame_list_base_i,
  input wire logic [9:0] frame_index_i,
  output logic [31:0] frame_entry_addr_o,
  output logic [3:0] iso_uframes_o,
  output logic [59:0] companion_sel_o,
  output logic [14:0] port_en_o
);
  localparam int P = cap_params_pkg::MAX_PORTS;

  // a zero port count is undefined, so it never reaches the register
  localparam logic [3:0] NP = (N_PORTS == 4'h0) ? 4'h1 : N_PORTS; // R04

  logic [2:0] strap_sync_r;
  logic [2:0] strap_fill_r;
  logic power_switch_present_r;
  cap_params_pkg::strap_state_t strap_state_r;
  cap_params_pkg::strap_state_t strap_state_nxt;
  logic [1:0] fls_r;
  logic [1:0] fls_nxt;
  logic [31:0] rd_data_r;
  logic [31:0] rd_data_nxt;
  logic rd_valid_r;
  cap_params_pkg::rd_req_t req;
  cap_params_pkg::struct_fields_t sp;
  cap_params_pkg::cap_fields_t cp;
  wire logic strap_stable;
  wire logic [31:0] struct_word;
  wire logic [31:0] cap_word;
  wire logic [31:0] route_lo_word;
  wire logic [31:0] route_hi_word;
  wire logic hit_struct;
  wire logic hit_cap;
  wire logic hit_lo;
  wire logic hit_hi;

  assign req = '{en: rd_en_i, addr: addr_i};

  // strap pin: three stages, accepted once the last two agree
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      strap_sync_r <= 3'h0;
      strap_fill_r <= 3'h0;
    end
    else
    begin
      strap_sync_r <= {strap_sync_r[1:0], power_strap_i};
      strap_fill_r <= {strap_fill_r[1:0], 1'b1};
    end
  end

  // reset zeros in the chain are not the pin, so wait until it has filled
  assign strap_stable = strap_fill_r[2] && (strap_sync_r[1] == strap_sync_r[2]);
  assign strap_state_nxt = (strap_state_r == cap_params_pkg::STRAP_WAIT && strap_stable) ?
                           cap_params_pkg::STRAP_DONE : strap_state_r;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      strap_state_r <= cap_params_pkg::STRAP_WAIT;
      power_switch_present_r <= cap_params_pkg::PPC_RST;
    end
    else
    begin
      strap_state_r <= strap_state_nxt;
      case (strap_state_r)
        cap_params_pkg::STRAP_WAIT:
          if (strap_stable)
            power_switch_present_r <= strap_sync_r[2]; // R03
        default:
          power_switch_present_r <= power_switch_present_r;
      endcase
    end
  end

  assign sp = '{companion_count: N_CC, ports_per_companion: PORTS_PER_COMPANION, routing_rule_flag: ROUTING_RULE_FLAG,
                power_switch_present: power_switch_present_r, n_ports: NP}; // R13
  assign cp = '{iso_schedule_threshold: ISO_SCHEDULE_THRESHOLD, frame_list_programmable: FRAME_LIST_PROGRAMMABLE,
                wide_address_capable: WIDE}; // R11

  // reserved bits are tied to zero; writes to this space have no target
  assign struct_word = {16'h0000, sp.companion_count, sp.ports_per_companion,
                        sp.routing_rule_flag, 2'h0, sp.power_switch_present, sp.n_ports}; // R14
  assign cap_word = {24'h00_0000, cp.iso_schedule_threshold, 2'h0,
                     cp.frame_list_programmable, cp.wide_address_capable}; // R14
  assign route_lo_word = ROUTE[31:0]; // R12
  assign route_hi_word = {4'h0, ROUTE[59:32]}; // R12

  assign hit_struct = req.addr == cap_params_pkg::STRUCT_OFS;
  assign hit_cap = req.addr == cap_params_pkg::CAP_OFS;
  assign hit_lo = req.addr == cap_params_pkg::ROUTE_LO_OFS;
  assign hit_hi = req.addr == cap_params_pkg::ROUTE_HI_OFS;
  assign rd_data_nxt = !req.en ? rd_data_r :
                       hit_struct ? struct_word :
                       hit_cap ? cap_word :
                       hit_lo ? route_lo_word :
                       hit_hi ? route_hi_word : 32'h0000_0000;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rd_data_r <= 32'h0000_0000;
      rd_valid_r <= 1'b0;
    end
    else
    begin
      rd_data_r <= rd_data_nxt;
      rd_valid_r <= req.en;
    end
  end

  assign rd_data_o = rd_data_r;
  assign rd_valid_o = rd_valid_r;

  // size bits stay zero when the list length is fixed
  assign fls_nxt = !cp.frame_list_programmable ? 2'h0 : // R08
                   cmd_wr_i ? cmd_wr_data_i[cap_params_pkg::FLS_POS +: 2] : fls_r; // R09

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      fls_r <= cap_params_pkg::FLS_RST;
    else
      fls_r <= fls_nxt;
  end

  assign frame_list_size_select_o = fls_r;
  assign frame_list_len_o = cap_params_pkg::FULL_LIST_LEN >> fls_r; // R08 R09
  // base low bits are not added in: the list is assumed page aligned
  assign frame_entry_addr_o = {frame_list_base_i[31:12],
                               frame_index_i & 10'(frame_list_len_o - 11'h001), 2'h0}; // R10

  assign iso_uframes_o = cp.iso_schedule_threshold[3] ?
                         cap_params_pkg::WHOLE_FRAME_UFRAMES :
                         {1'b0, cp.iso_schedule_threshold[2:0]}; // R06 R07

  assign port_reg_hit_o = port_reg_idx_i < sp.n_ports; // R05

  genvar g;
  generate
    for (g = 0; g < P; g++)
    begin : g_pwr
      // without switches every enabled port is always powered
      assign port_power_o[g] = port_en_o[g] &
                               (!sp.power_switch_present | port_power_req_i[g]); // R03
    end
  endgenerate

  port_router #(
    .PORTS(P)
  ) u_router (
    .routing_rule_flag_i(sp.routing_rule_flag),
    .ports_per_companion_i(sp.ports_per_companion),
    .n_ports_i(sp.n_ports),
    .companion_route_array_i(ROUTE),
    .companion_sel_o(companion_sel_o),
    .port_en_o(port_en_o)
  );

  wire logic unused_wr;
  assign unused_wr = wr_en_i ^ (^wr_data_i);

  nports_valid_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R04
    rd_valid_o && $past(addr_i) == cap_params_pkg::STRUCT_OFS |-> rd_data_o[3:0] != 4'h0)
    else $error("port count read as zero");
  read_latency_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R14
    rd_en_i && addr_i == cap_params_pkg::CAP_OFS |=> rd_valid_o && rd_data_o[31:8] == 24'h0
    && rd_data_o[3:2] == 2'h0)
    else $error("capability word reserved bits not zero");
  write_ignored_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R14
    rd_en_i && addr_i == cap_params_pkg::STRUCT_OFS ##1 wr_en_i [*2] ##1
    rd_en_i && addr_i == cap_params_pkg::STRUCT_OFS |=> rd_data_o == $past(rd_data_o, 3))
    else $error("write changed a read-only field");
  fixed_fls_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R08
    !cp.frame_list_programmable |-> fls_r == 2'h0 && frame_list_len_o == 11'h400)
    else $error("size bits nonzero with fixed list");
  fls_follow_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R09
    cp.frame_list_programmable && cmd_wr_i |=> fls_r == $past(cmd_wr_data_i[3:2]))
    else $error("frame list size write not taken");
  port_decode_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R05
    port_reg_hit_o == (port_reg_idx_i < sp.n_ports) && $countones(port_en_o) == int'(sp.n_ports))
    else $error("port decode disagrees with port count");
  iso_thresh_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R06
    !cp.iso_schedule_threshold[3] |-> iso_uframes_o == {1'b0, cp.iso_schedule_threshold[2:0]})
    else $error("iso threshold micro frames wrong");
  group_route_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R01
    !sp.routing_rule_flag && sp.ports_per_companion != 4'h0 && sp.n_ports > 4'h1 |->
    companion_sel_o[7:4] == ((sp.ports_per_companion > 4'h1) ? 4'h0 : 4'h1))
    else $error("grouped routing wrong for second port");
  list_route_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R02
    sp.routing_rule_flag |-> companion_sel_o[3:0] == ROUTE[3:0])
    else $error("listed routing wrong for first port");
  power_fixed_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R03
    !sp.power_switch_present |-> port_power_o == port_en_o)
    else $error("unswitched port not powered");
  consistent_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R13
    8'(sp.ports_per_companion) * 8'(sp.companion_count) >= 8'(sp.n_ports)
    || sp.routing_rule_flag)
    else $error("ports per companion inconsistent");
  strap_done_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R03
    $rose(rst_n_i) |-> ##[1:8] strap_state_r == cap_params_pkg::STRAP_DONE)
    else $error("strap never captured");

  read_struct_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_en_i && addr_i == cap_params_pkg::STRUCT_OFS ##1 rd_valid_o);
  fls_change_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    cmd_wr_i ##1 fls_r != 2'h0);
  unmapped_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_en_i && !(hit_struct || hit_cap || hit_lo || hit_hi) ##1 rd_data_o == 32'h0);
endmodule // cap_params

//--- cap_params_pkg.sv
// constants and carrier types for the host controller capability parameters
package cap_params_pkg;
  localparam logic [7:0] STRUCT_OFS = 8'h04;
  localparam logic [7:0] CAP_OFS = 8'h08;
  localparam logic [7:0] ROUTE_LO_OFS = 8'h0c;
  localparam logic [7:0] ROUTE_HI_OFS = 8'h10;
  // structural parameter field positions
  localparam int NPORTS_POS = 0;
  localparam int PPC_POS = 4;
  localparam int PRR_POS = 7;
  localparam int NPCC_POS = 8;
  localparam int NCC_POS = 12;
  // capability parameter field positions
  localparam int WIDE_POS = 0;
  localparam int FRAME_LIST_PROGRAMMABLE_POS = 1;
  localparam int IST_POS = 4;
  // command register frame list size field position
  localparam int FLS_POS = 2;
  // reset values and fixed sizes
  localparam logic [3:0] NPORTS_RST = 4'h4;
  localparam logic [3:0] NPCC_RST = 4'h2;
  localparam logic [3:0] NCC_RST = 4'h2;
  localparam logic PRR_RST = 1'b1;
  localparam logic PPC_RST = 1'b1;
  localparam logic [3:0] IST_RST = 4'h1;
  localparam logic FRAME_LIST_PROGRAMMABLE_RST = 1'b1;
  localparam logic WIDE_RST = 1'b0;
  localparam logic [1:0] FLS_RST = 2'h0;
  localparam logic [59:0] ROUTE_RST = 60'h000_0000_0000_1100;
  localparam int MAX_PORTS = 15;
  localparam int ROUTE_W = 4;
  localparam logic [10:0] FULL_LIST_LEN = 11'h400;
  localparam logic [3:0] WHOLE_FRAME_UFRAMES = 4'h8;

  typedef struct packed {
    logic [3:0] companion_count;
    logic [3:0] ports_per_companion;
    logic routing_rule_flag;
    logic power_switch_present;
    logic [3:0] n_ports;
  } struct_fields_t;

  typedef struct packed {
    logic [3:0] iso_schedule_threshold;
    logic frame_list_programmable;
    logic wide_address_capable;
  } cap_fields_t;

  typedef struct packed {
    logic en;
    logic [7:0] addr;
  } rd_req_t;

  typedef enum logic {
    STRAP_WAIT = 1'b0,
    STRAP_DONE = 1'b1
  } strap_state_t;
endpackage

//--- port_router.sv
// per-port companion controller assignment
`timescale 1ns/100ps
module port_router #(
  parameter int PORTS = 15
) (
  input wire logic routing_rule_flag_i,
  input wire logic [3:0] ports_per_companion_i,
  input wire logic [3:0] n_ports_i,
  input wire logic [PORTS*4-1:0] companion_route_array_i,
  output logic [PORTS*4-1:0] companion_sel_o,
  output logic [PORTS-1:0] port_en_o
);
  genvar g;
  generate
    for (g = 0; g < PORTS; g++)
    begin : g_port
      localparam logic [3:0] IDX = 4'(g);
      wire logic [3:0] grouped;
      wire logic [3:0] listed;
      wire logic valid;
      // a zero group size would divide by zero, so it routes all to the first
      assign grouped = (ports_per_companion_i == 4'h0) ? 4'h0 : IDX / ports_per_companion_i; // R01
      assign listed = companion_route_array_i[g*4 +: 4]; // R12
      assign valid = IDX < n_ports_i; // R02
      assign port_en_o[g] = valid;
      assign companion_sel_o[g*4 +: 4] = !valid ? 4'h0 :
                                         routing_rule_flag_i ? listed : grouped; // R02
    end
  endgenerate
endmodule // port_router

//--- usb_host_capability_params_test.sv
// self-checking bench for the capability parameter register bank
`timescale 1ns/100ps
module usb_host_capability_params_test;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic rd_en_i = 1'b0;
  logic wr_en_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wr_data_i = 32'h0;
  logic power_strap_i = 1'b1;
  logic [14:0] port_power_req_i = 15'h0;
  logic [3:0] port_reg_idx_i = 4'h0;
  logic cmd_wr_i = 1'b0;
  logic [31:0] cmd_wr_data_i = 32'h0;
  logic [31:0] frame_list_base_i = 32'h0;
  logic [9:0] frame_index_i = 10'h0;
  logic [31:0] rd_data_o, frame_entry_addr_o, f_data, f_entry;
  logic rd_valid_o, port_reg_hit_o, f_valid, f_hit;
  logic [14:0] port_power_o, port_en_o, f_en, f_pwr;
  logic [1:0] frame_list_size_select_o, f_fls;
  logic [10:0] frame_list_len_o, f_len;
  logic [3:0] iso_uframes_o, f_iso;
  logic [59:0] companion_sel_o, f_sel;
  int errors = 0;
  int cmp_count = 0;
  logic [31:0] seed = 32'h5ca9f343;
  localparam logic [14:0] EN = (15'h1 << cap_params_pkg::NPORTS_RST) - 15'h1;

  cap_params dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .rd_en_i(rd_en_i), .wr_en_i(wr_en_i),
    .addr_i(addr_i), .wr_data_i(wr_data_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
    .power_strap_i(power_strap_i), .port_power_req_i(port_power_req_i),
    .port_power_o(port_power_o), .port_reg_idx_i(port_reg_idx_i),
    .port_reg_hit_o(port_reg_hit_o), .cmd_wr_i(cmd_wr_i), .cmd_wr_data_i(cmd_wr_data_i),
    .frame_list_size_select_o(frame_list_size_select_o), .frame_list_len_o(frame_list_len_o),
    .frame_list_base_i(frame_list_base_i), .frame_index_i(frame_index_i),
    .frame_entry_addr_o(frame_entry_addr_o), .iso_uframes_o(iso_uframes_o),
    .companion_sel_o(companion_sel_o), .port_en_o(port_en_o));
  // grouped routing, fixed list, whole-frame threshold, wide pointers
  cap_params #(.N_PORTS(4'h6), .PORTS_PER_COMPANION(4'h3), .ROUTING_RULE_FLAG(1'b0), .ISO_SCHEDULE_THRESHOLD(4'h9), .FRAME_LIST_PROGRAMMABLE(1'b0),
    .WIDE(1'b1)) dut_fixed (.clk_i(clk_i), .rst_n_i(rst_n_i), .rd_en_i(rd_en_i),
    .wr_en_i(wr_en_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .rd_data_o(f_data),
    .rd_valid_o(f_valid), .power_strap_i(power_strap_i), .port_power_req_i(port_power_req_i),
    .port_power_o(f_pwr), .port_reg_idx_i(port_reg_idx_i), .port_reg_hit_o(f_hit),
    .cmd_wr_i(cmd_wr_i), .cmd_wr_data_i(cmd_wr_data_i), .frame_list_size_select_o(f_fls),
    .frame_list_len_o(f_len), .frame_list_base_i(frame_list_base_i),
    .frame_index_i(frame_index_i), .frame_entry_addr_o(f_entry), .iso_uframes_o(f_iso),
    .companion_sel_o(f_sel), .port_en_o(f_en));

  initial
  begin
    forever #12.5 clk_i = ~clk_i;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [31:0] exp_reg(input logic [7:0] a, input logic strap);
    case (a)
      8'h04: return {16'h0, cap_params_pkg::NCC_RST, cap_params_pkg::NPCC_RST,
        cap_params_pkg::PRR_RST, 2'b00, strap, cap_params_pkg::NPORTS_RST};
      8'h08: return {24'h0, cap_params_pkg::IST_RST, 2'b00, cap_params_pkg::FRAME_LIST_PROGRAMMABLE_RST,
        cap_params_pkg::WIDE_RST};
      8'h0c: return cap_params_pkg::ROUTE_RST[31:0];
      8'h10: return {4'h0, cap_params_pkg::ROUTE_RST[59:32]};
      default: return 32'h0;
    endcase
  endfunction

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // answer stands right after the taking edge; an idle cycle follows
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    rd_en_i = 1'b1;
    addr_i = a;
    @(posedge clk_i);
    #2;
    rd_en_i = 1'b0;
    check("rd_valid", {rd_valid_o, f_valid}, 2'b11);
    d = rd_data_o;
    @(posedge clk_i);
    #2;
  endtask

  task automatic do_reset(input logic strap);
    int n;
    logic [31:0] d;
    rst_n_i = 1'b0;
    power_strap_i = strap;
    repeat (6) @(posedge clk_i);
    #2;
    check("rst_data", rd_data_o, 32'h0);
    check("rst_fls", frame_list_size_select_o, 2'h0);
    rst_n_i = 1'b1;
    n = 0;
    d = 32'h0;
    d[4] = ~strap;
    // strap sync delay is bounded, so poll a few reads only
    while (d[4] !== strap && n < 8)
    begin
      rd(8'h04, d);
      n++;
    end
    check("strap_capture", d[4], strap);
  endtask

  initial
  begin
    logic [31:0] d;
    logic [7:0] adr [7] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h00, 8'h14, 8'hfc};
    logic [59:0] gs;
    int k;
    do_reset(1'b1);
    for (k = 0; k < 7; k++)
    begin
      wr_en_i = 1'b1;
      addr_i = adr[k];
      wr_data_i = seed;
      seed = lfsr(seed);
      @(posedge clk_i);
      #2;
    end
    // read, two writes, read: the writes must not disturb the answer
    rd_en_i = 1'b1;
    addr_i = 8'h04;
    @(posedge clk_i);
    #2;
    rd_en_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #2;
    rd_en_i = 1'b1;
    wr_en_i = 1'b0;
    @(posedge clk_i);
    #2;
    rd_en_i = 1'b0;
    check("wr_ignored", {rd_valid_o, rd_data_o}, {1'b1, exp_reg(8'h04, 1'b1)});
    for (k = 0; k < 7; k++)
    begin
      rd(adr[k], d);
      check("reg", d, exp_reg(adr[k], 1'b1));
    end
    rd(8'h08, d);
    check("fixed_cap", f_data, 32'h0000_0091);
    rd(8'h04, d);
    check("fixed_struct", f_data, 32'h0000_2316);
    $display("test register map done");
    rd_en_i = 1'b1;
    addr_i = 8'h08;
    @(posedge clk_i);
    #2;
    check("b2b_first", {rd_valid_o, rd_data_o}, {1'b1, exp_reg(8'h08, 1'b1)});
    addr_i = 8'h0c;
    @(posedge clk_i);
    #2;
    rd_en_i = 1'b0;
    check("b2b_second", {rd_valid_o, rd_data_o}, {1'b1, exp_reg(8'h0c, 1'b1)});
    @(posedge clk_i);
    #2;
    check("b2b_hold", {rd_valid_o, rd_data_o}, {1'b0, exp_reg(8'h0c, 1'b1)});
    $display("test back to back done");
    for (k = 0; k < 16; k++)
    begin
      port_reg_idx_i = k[3:0];
      @(posedge clk_i);
      #2;
      check("port_hit", {port_reg_hit_o, f_hit},
        {k < cap_params_pkg::NPORTS_RST, k < 6});
    end
    gs = 60'h0;
    for (k = 0; k < 6; k++)
      gs[k*4+:4] = k / 3;
    check("port_en", {f_en, port_en_o}, {15'h3f, EN});
    check("route_sel", companion_sel_o,
      cap_params_pkg::ROUTE_RST & ((60'h1 << (4 * cap_params_pkg::NPORTS_RST)) - 60'h1));
    check("group_sel", f_sel, gs);
    check("iso", {iso_uframes_o, f_iso}, {cap_params_pkg::IST_RST,
      cap_params_pkg::WHOLE_FRAME_UFRAMES});
    for (k = 0; k < 8; k++)
    begin
      port_power_req_i = seed[14:0];
      seed = lfsr(seed);
      @(posedge clk_i);
      #2;
      check("power_sw", {port_power_o, f_pwr},
        {EN & port_power_req_i, 15'h3f & port_power_req_i});
    end
    $display("test ports done");
    for (k = 0; k < 8; k++)
    begin
      cmd_wr_i = 1'b1;
      cmd_wr_data_i = (seed & ~32'hc) | {28'h0, k[1:0], 2'b00};
      seed = lfsr(seed);
      frame_list_base_i = seed;
      frame_index_i = seed[21:12];
      @(posedge clk_i);
      #2;
      check("fls", {frame_list_size_select_o, frame_list_len_o},
        {k[1:0], cap_params_pkg::FULL_LIST_LEN >> k[1:0]});
      check("fixed_fls", {f_fls, f_len}, {2'h0, 11'h400});
      check("entry", {frame_entry_addr_o, f_entry}, {seed[31:12],
        seed[21:12] & (10'h3ff >> k[1:0]), 2'b00, seed[31:12], seed[21:12], 2'b00});
      seed = lfsr(seed);
    end
    cmd_wr_i = 1'b0;
    $display("test frame list done");
    do_reset(1'b0);
    rd(8'h04, d);
    check("no_switch", d, exp_reg(8'h04, 1'b0));
    port_power_req_i = 15'h0;
    @(posedge clk_i);
    #2;
    check("power_fixed", {port_power_o, f_pwr}, {EN, 15'h3f});
    $display("test strap low done");
    close_out();
  end
endmodule // usb_host_capability_params_test
